/* File: dv/fdc_ctl_regs_assertions.sv */
/*
 * Port checker for the floppy drive control register bank.
 * Assumes it is bound to fdc_ctl_regs, which has one clock domain.
 */
`timescale 1ns/1ps
`include "fdc_ctl_regs.svh"
module fdc_ctl_regs_assertions #(
    parameter int SOFT_RESET_CYCLES = 1
) (
    input wire logic                   i_ref_clk,
    input wire logic                   i_rst_b,
    input wire fdc_ctl_pkg::host_req_t i_host,
    input wire fdc_ctl_pkg::sys_mode_t i_sys_mode,
    input wire logic                   i_ext_decode,
    input wire logic                   i_swap_drives,
    input wire logic [7:0]             o_rdata,
    input wire logic                   o_rdata_oe_n,
    input wire fdc_ctl_pkg::drive_pins_t o_drive,
    input wire logic                   o_soft_reset,
    input wire logic                   o_dma_req_oe_n,
    input wire logic                   o_floppy_irq_oe_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] hi_q;
    logic       enh;
    assign enh = (i_sys_mode == fdc_ctl_pkg::SYS_ENHANCED);
    // Saturates so a core held in reset for long cannot wrap around.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) hi_q <= 8'h00;
        else if (!o_soft_reset) hi_q <= 8'h00;
        else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_dor_wr;
        i_host.wr && i_host.addr == `OFS_DRIVE_OUTPUT;
    endsequence
    sequence s_stat_rd;
        i_host.rd && i_host.addr == `OFS_STATUS_SECOND;
    endsequence
    property p_refuse;
        s_stat_rd ##0 (i_sys_mode == fdc_ctl_pkg::SYS_BASIC) |=> o_rdata_oe_n;
    endproperty
    a_refuse: assert property (p_refuse) else $error("status drove bus");
    property p_resv;
        s_stat_rd ##0 enh |=> !o_rdata_oe_n && o_rdata[7:6] == 2'b11;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits wrong");
    property p_motor_out_1;
        s_stat_rd ##0 (enh && !i_ext_decode && !i_swap_drives)
            |=> o_rdata[1] == !o_drive.motor_n[1];
    endproperty
    a_motor_out_1: assert property (p_motor_out_1) else $error("motor 1 status wrong");
    property p_red_sel;
        s_stat_rd ##0 (i_sys_mode == fdc_ctl_pkg::SYS_REDUCED)
            |=> o_rdata[1:0] == o_drive.sel_n[3:2]
                && o_rdata[6:5] == o_drive.sel_n[1:0];
    endproperty
    a_red_sel: assert property (p_red_sel) else $error("select status wrong");
    property p_one_sel;
        (!i_ext_decode) [*3] |-> $onehot0(~o_drive.sel_n);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_motor;
        s_dor_wr ##0 (!i_ext_decode && !i_swap_drives)
            |-> ##2 o_drive.motor_n == ~$past(i_host.wdata[7:4], 2);
    endproperty
    a_motor: assert property (p_motor) else $error("motor pins wrong");
    property p_swap;
        s_dor_wr ##0 (!i_ext_decode && i_swap_drives) |-> ##2
            o_drive.motor_n[1:0] == ~{$past(i_host.wdata[4], 2),
                                      $past(i_host.wdata[5], 2)};
    endproperty
    a_swap: assert property (p_swap) else $error("swapped motors wrong");
    property p_ext;
        s_dor_wr ##0 i_ext_decode |-> ##2 o_drive.motor_n[1]
            && o_drive.sel_n[1:0] == $past(i_host.wdata[1:0], 2);
    endproperty
    a_ext: assert property (p_ext) else $error("external decode wrong");
    property p_oe_pair;
        o_dma_req_oe_n == o_floppy_irq_oe_n;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
    property p_enh_on;
        enh [*3] |-> !o_dma_req_oe_n && !o_floppy_irq_oe_n;
    endproperty
    a_enh_on: assert property (p_enh_on) else $error("pins disabled");
    property p_srst;
        $fell(o_soft_reset) |-> int'(hi_q) >= SOFT_RESET_CYCLES;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset too short");
endmodule

/* File: dv/fdc_ctl_regs_tb_top.sv */
/*
 * Self-checking bench for the floppy drive control register bank.
 * Assumes host strobes are one-cycle pulses set 1 ns after an edge.
 */
`timescale 1ns/1ps
module fdc_ctl_regs_tb_top;
    localparam int SR_CYC = 4;
    logic                     i_ref_clk;
    logic                     i_rst_b;
    fdc_ctl_pkg::host_req_t   host;
    fdc_ctl_pkg::sys_mode_t   mode;
    fdc_ctl_pkg::drive_pins_t drv;
    logic                     ext, swap, write_gate_out, wdat, rdat, drv2_n;
    logic                     dreq, irq, ack_n, tc, oe_n, srst;
    logic                     o_req, req_oe_n, o_irq, irq_oe_n, o_ack_n, o_tc;
    logic [7:0]               rdata, v;
    logic [3:0]               s;
    int                       miscompares, tests_run;
    fdc_ctl_regs #(.SOFT_RESET_CYCLES(SR_CYC)) fdc_ctl_regs_i (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_host(host),
        .i_sys_mode(mode), .i_ext_decode(ext), .i_swap_drives(swap),
        .i_write_gate_out(write_gate_out), .i_read_data(rdat),
        .i_write_data(wdat), .i_second_drive_present_n(drv2_n),
        .i_dma_req(dreq), .i_floppy_irq(irq), .i_dma_ack_n(ack_n),
        .i_term_count(tc), .o_rdata(rdata), .o_rdata_oe_n(oe_n),
        .o_drive(drv), .o_soft_reset(srst), .o_dma_req(o_req),
        .o_dma_req_oe_n(req_oe_n), .o_floppy_irq_out(o_irq),
        .o_floppy_irq_oe_n(irq_oe_n), .o_dma_ack_n(o_ack_n),
        .o_term_count(o_tc));
    fdc_disk_model fdc_disk_model_i (.i_ref_clk(i_ref_clk), .i_drive(drv),
        .o_read_data(rdat), .o_second_drive_present_n(drv2_n));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host = '{a, d, 1'b1, 1'b0};
        step(1);
        host.wr = 1'b0;
        step(3);
    endtask
    // With want_oe high the bus must stay released and data is ignored.
    task automatic rd(input logic [9:0] a, input logic [7:0] e,
                      input logic want_oe);
        host = '{a, 8'h00, 1'b0, 1'b1};
        step(1);
        host.rd = 1'b0;
        check({7'h00, oe_n}, {7'h00, want_oe});
        if (!want_oe) check(rdata, e);
        step(1);
    endtask
    task automatic clear_latches;
        host = '{10'h3F7, 8'h00, 1'b0, 1'b1};
        step(1);
        host.rd = 1'b0;
        step(1);
    endtask
    task automatic pulse_wdat;
        wdat = 1'b1;
        step(2);
        wdat = 1'b0;
        step(4);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #40000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {i_rst_b, ext, swap, write_gate_out, wdat} = 5'h00;
        {dreq, irq, ack_n, tc} = 4'hD;
        host = '0;
        mode = fdc_ctl_pkg::SYS_ENHANCED;
        miscompares = 0;
        tests_run = 0;
        repeat (4) @(posedge i_ref_clk);
        #1;
        check({6'h00, req_oe_n, irq_oe_n}, 8'h00);
        i_rst_b = 1'b1;
        step(1);
        check(drv, 8'hFF);
        check({7'h00, srst}, 8'h01);
        rd(10'h3F2, 8'h00, 1'b0);
        rd(10'h3F1, 8'hC0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(10'h3F3, 8'hFC | 8'(c));
            rd(10'h3F3, 8'(c), 1'b0);
        end
        wr(10'h3F2, 8'h1C);
        step(SR_CYC);
        check({7'h00, srst}, 8'h00);
        // Clear then set the reset bit on consecutive edges.
        host = '{10'h3F2, 8'h18, 1'b1, 1'b0};
        step(1);
        host.wdata = 8'h1C;
        step(1);
        host.wr = 1'b0;
        step(SR_CYC - 1);
        check({7'h00, srst}, 8'h01);
        step(SR_CYC + 4);
        check({7'h00, srst}, 8'h00);
        rd(10'h3F3, 8'h03, 1'b0);
        rd(10'h3F2, 8'h1C, 1'b0);
        for (int e = 0; e < 2; e++) begin
            ext = e[0];
            for (int k = 0; k < 8; k++) begin
                v = 8'h0C | 8'(k % 4) | (k > 3 ? 8'h10 << (k % 4) : 8'h00);
                s = ~(4'h1 << (k % 4));
                wr(10'h3F2, v);
                if (e == 0) check(drv, k > 3 ? {s, s} : 8'hFF);
                else check({4'h0, drv.sel_n[1:0], drv.motor_n[1:0]}, {4'h0, v[1:0], 1'b1, k < 4});
                if (e == 0) rd(10'h3F1, {2'b11, v[0], 3'b000, v[5:4]}, 1'b0);
            end
        end
        ext = 1'b0;
        wr(10'h3F2, 8'hFE);
        check(drv, 8'hB0);
        swap = 1'b1;
        wr(10'h3F2, 8'h1C);
        check(drv, 8'hDD);
        wr(10'h3F2, 8'h6E);
        check(drv, 8'hBA);
        swap = 1'b0;
        wr(10'h3F2, 8'h1C);
        write_gate_out = 1'b1;
        fdc_disk_model_i.emit_read(3);
        pulse_wdat();
        rd(10'h3F1, 8'hDD, 1'b0);
        mode = fdc_ctl_pkg::SYS_REDUCED;
        write_gate_out = 1'b0;
        step(4);
        clear_latches();
        rd(10'h3F1, 8'h43, 1'b0);
        write_gate_out = 1'b1;
        fdc_disk_model_i.emit_read(1);
        write_gate_out = 1'b0;
        pulse_wdat();
        rd(10'h3F1, 8'h5F, 1'b0);
        clear_latches();
        rd(10'h3F1, 8'h43, 1'b0);
        mode = fdc_ctl_pkg::SYS_BASIC;
        wr(10'h3F2, 8'h14);
        check({4'h0, req_oe_n, irq_oe_n, o_ack_n, o_tc}, 8'h0E);
        rd(10'h3F1, 8'h00, 1'b1);
        rd(10'h3F5, 8'h00, 1'b1);
        wr(10'h3F2, 8'h1C);
        check({2'h0, o_irq, o_req, req_oe_n, irq_oe_n, o_ack_n, o_tc}, 8'h31);
        mode = fdc_ctl_pkg::SYS_ENHANCED;
        wr(10'h3F2, 8'h14);
        check({6'h00, req_oe_n, irq_oe_n}, 8'h00);
        tally_and_finish();
    end
endmodule
bind fdc_ctl_regs fdc_ctl_regs_assertions #(
    .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)
) chk_i (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_host(i_host),
    .i_sys_mode(i_sys_mode), .i_ext_decode(i_ext_decode),
    .i_swap_drives(i_swap_drives), .o_rdata(o_rdata),
    .o_rdata_oe_n(o_rdata_oe_n), .o_drive(o_drive),
    .o_soft_reset(o_soft_reset), .o_dma_req_oe_n(o_dma_req_oe_n),
    .o_floppy_irq_oe_n(o_floppy_irq_oe_n));

/* File: dv/fdc_disk_model.sv */
/*
 * Behavioural floppy drive on the disk pins: reports presence and
 * sends read data pulses on request.
 * Assumes the bench calls emit_read just after a rising clock edge.
 */
`timescale 1ns/1ps
module fdc_disk_model #(
    parameter logic DRIVE_PRESENT_N = 1'b0
) (
    input  wire logic                     i_ref_clk,
    input  wire fdc_ctl_pkg::drive_pins_t i_drive,
    output logic                          o_read_data,
    output logic                          o_second_drive_present_n
);
    assign o_second_drive_present_n = DRIVE_PRESENT_N;
    initial o_read_data = 1'b0;
    // An unselected drive leaves the line at its pulled-down level.
    task automatic emit_read(input int n);
        repeat (n) begin
            o_read_data = (i_drive.sel_n != 4'hF);
            repeat (2) @(posedge i_ref_clk);
            #1 o_read_data = 1'b0;
            repeat (2) @(posedge i_ref_clk);
            #1;
        end
    endtask
endmodule

/* File: rtl/fdc_ctl_pkg.sv */
/*
 * Types shared by the floppy drive control register bank.
 * Assumes the constants header is included by the design files.
 */
package fdc_ctl_pkg;

    typedef enum logic [1:0] {
        SYS_BASIC    = 2'b00,
        SYS_REDUCED  = 2'b01,
        SYS_ENHANCED = 2'b10
    } sys_mode_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } host_req_t;

    typedef struct packed {
        logic [3:0] sel_n;
        logic [3:0] motor_n;
    } drive_pins_t;

endpackage

/* File: rtl/fdc_ctl_regs.sv */
/*
 * Floppy drive control register bank: drive output control, tape
 * select and the second disk status register in both layouts, plus
 * the drive select and motor decode onto active-low drive pins.
 * Assumes host strobes are synchronous one-cycle pulses on i_ref_clk and
 * the disk pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "fdc_ctl_regs.svh"

// Function
// - Enhanced status bit1 mirrors motor 1
// - Enhanced status bit2 shows write gate
// - Enhanced bits3,4 toggle on data edges
// - Enhanced bit5 copies drive select bit0
// - Enhanced bits6,7 always read one
// - Reduced layout returns selects and drive-present
// - Reduced bit2 latches write gate rise
// - Reduced bits3,4 latch data edges, input-read clears
// - Output control writable anytime, hard reset zero
// - Bits1:0 choose one drive of four
// - Bit2 low holds controller in reset
// - Back-to-back clear/set write is valid reset
// - Basic/reduced: bit3 gates DMA and interrupt
// - Enhanced: DMA and interrupt pins always enabled
// - Bits7:4 drive motors 3 to 0
// - Internal decode: selects need motor bit
// - External decode: encoded selects, one motor
// - Tape register read/write, unused, high bits read zero
// - Tape select codes none or drives 1-3
// - Other modes float status register reads
module fdc_ctl_regs #(
    parameter int SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst_b,
    input  wire fdc_ctl_pkg::host_req_t  i_host,
    input  wire fdc_ctl_pkg::sys_mode_t  i_sys_mode,
    input  wire logic                    i_ext_decode,
    input  wire logic                    i_swap_drives,
    input  wire logic                    i_write_gate_out,
    input  wire logic                    i_read_data,
    input  wire logic                    i_write_data,
    input  wire logic                    i_second_drive_present_n,
    input  wire logic                    i_dma_req,
    input  wire logic                    i_floppy_irq,
    input  wire logic                    i_dma_ack_n,
    input  wire logic                    i_term_count,
    output logic [7:0]                   o_rdata,
    output logic                         o_rdata_oe_n,
    output fdc_ctl_pkg::drive_pins_t     o_drive,
    output logic                         o_soft_reset,
    output logic                         o_dma_req,
    output logic                         o_dma_req_oe_n,
    output logic                         o_floppy_irq_out,
    output logic                         o_floppy_irq_oe_n,
    output logic                         o_dma_ack_n,
    output logic                         o_term_count
);

    // A zero-length stretch would let a back-to-back clear and set slip by.
    if (SOFT_RESET_CYCLES < 1) begin : g_bad_stretch
        $error("SOFT_RESET_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    // Disk pin synchronisers and edge detection.

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [2:0] pin_d_q;
    logic       write_gate_out_s;
    logic       rdat_s;
    logic       wdat_s;
    logic       drv2_s;
    logic       write_gate_out_rise;
    logic       rdat_fall;
    logic       wdat_fall;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_d_q  <= 3'h0;
        end else begin
            pin_s1_q <= {i_second_drive_present_n, i_write_data,
                         i_read_data, i_write_gate_out};
            pin_s2_q <= pin_s1_q;
            pin_d_q  <= pin_s2_q[2:0];
        end
    end

    assign write_gate_out_s    = pin_s2_q[0];
    assign rdat_s     = pin_s2_q[1];
    assign wdat_s     = pin_s2_q[2];
    assign drv2_s     = pin_s2_q[3];
    // Data pulses are active high; the trailing edge is the inactive one.
    assign write_gate_out_rise = write_gate_out_s & ~pin_d_q[0];
    assign rdat_fall  = ~rdat_s & pin_d_q[1];
    assign wdat_fall  = ~wdat_s & pin_d_q[2];

    // The host acknowledge and terminal count pins are asynchronous too.
    logic [1:0] hpin_s1_q;
    logic [1:0] hpin_s2_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hpin_s1_q <= 2'h1;
            hpin_s2_q <= 2'h1;
        end else begin
            hpin_s1_q <= {i_term_count, i_dma_ack_n};
            hpin_s2_q <= hpin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host access decode.

    // Full ten-bit compare: aliases of the port addresses are ignored.
    function automatic logic addr_hit(
        input fdc_ctl_pkg::host_req_t req,
        input logic [9:0]             ofs
    );
        return req.addr == ofs;
    endfunction

    logic wr_doc;
    logic wr_tds;
    logic rd_din;

    always_comb begin
        wr_doc = 1'b0;
        wr_tds = 1'b0;
        rd_din = 1'b0;
        if (i_host.wr && addr_hit(i_host, `OFS_DRIVE_OUTPUT)) begin
            wr_doc = 1'b1;
        end else if (i_host.wr && addr_hit(i_host, `OFS_TAPE_SELECT)) begin
            wr_tds = 1'b1;
        end else if (i_host.rd && addr_hit(i_host, `OFS_DIGITAL_INPUT)) begin
            rd_din = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive output control and tape select registers.

    logic [7:0] drive_output_control_q;
    // Only the two select bits are stored; only the host read-back uses them.
    logic [1:0] tape_drive_select_q;

    // Only the hard reset clears these; the soft reset bit never does.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drive_output_control_q <= `DOC_RESET_VAL;
        end else if (wr_doc) begin
            drive_output_control_q <= i_host.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tape_drive_select_q <= `TDS_RESET_VAL;
        end else if (wr_tds) begin
            tape_drive_select_q <= i_host.wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset stretch: a clear immediately followed by a set still
    // gives the core a full minimum-width reset pulse.

    localparam int CW = $clog2(SOFT_RESET_CYCLES + 1);
    logic [CW-1:0] srst_cnt_q;
    logic          soft_rst_bit;

    assign soft_rst_bit = ~drive_output_control_q[`DOC_SOFT_RESET_N];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            srst_cnt_q <= '0;
        end else if (soft_rst_bit) begin
            srst_cnt_q <= CW'(SOFT_RESET_CYCLES);
        end else if (srst_cnt_q != '0) begin
            srst_cnt_q <= srst_cnt_q - CW'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_soft_reset <= 1'b1;
        end else begin
            o_soft_reset <= soft_rst_bit || srst_cnt_q != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status latches for both layouts; a set in the clearing cycle wins.

    logic rd_tog_q;
    logic wr_tog_q;
    logic write_gate_out_lat_q;
    logic rd_lat_q;
    logic wr_lat_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_tog_q <= 1'b0;
            wr_tog_q <= 1'b0;
        end else begin
            rd_tog_q <= rd_tog_q ^ rdat_fall;
            wr_tog_q <= wr_tog_q ^ wdat_fall;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            write_gate_out_lat_q <= 1'b0;
            rd_lat_q    <= 1'b0;
            wr_lat_q    <= 1'b0;
        end else begin
            write_gate_out_lat_q <= write_gate_out_rise | (write_gate_out_lat_q & ~rd_din);
            rd_lat_q    <= rdat_fall | (rd_lat_q & ~rd_din);
            wr_lat_q    <= wdat_fall | (wr_lat_q & ~rd_din);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive select and motor decode.

    // External decode puts the swapped drive number on the selects; its single
    // motor bit is picked with the raw, unswapped number.
    function automatic fdc_ctl_pkg::drive_pins_t decode_drive(
        input logic [7:0] doc,
        input logic       ext,
        input logic       swap
    );
        fdc_ctl_pkg::drive_pins_t p;
        logic [3:0]               mot;
        logic [1:0]               num;
        p   = '{sel_n: 4'hF, motor_n: 4'hF};
        mot = doc[7:4];
        num = doc[1:0];
        if (swap) begin
            mot = {mot[3:2], mot[0], mot[1]};
            num = (num[1] == 1'b0) ? {1'b0, ~num[0]} : num;
        end
        if (ext) begin
            p.sel_n   = {2'b11, num};
            p.motor_n = {3'b111, ~doc[4 + doc[1:0]]};
        end else begin
            p.motor_n = ~mot;
            if (mot[num]) begin
                p.sel_n[num] = 1'b0;
            end
        end
        return p;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drive <= '{sel_n: 4'hF, motor_n: 4'hF};
        end else begin
            o_drive <= decode_drive(drive_output_control_q, i_ext_decode,
                                    i_swap_drives);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA and interrupt pin gating.

    logic pins_en;
    assign pins_en = (i_sys_mode == fdc_ctl_pkg::SYS_ENHANCED)
                   | drive_output_control_q[`DOC_DMA_IRQ_EN];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dma_req         <= 1'b0;
            o_floppy_irq_out  <= 1'b0;
            o_dma_ack_n       <= 1'b1;
            o_term_count      <= 1'b0;
        end else begin
            o_dma_req         <= i_dma_req;
            o_floppy_irq_out  <= i_floppy_irq;
            o_dma_ack_n       <= pins_en ? hpin_s2_q[0] : 1'b1;
            o_term_count      <= pins_en & hpin_s2_q[1];
        end
    end

    // No hard reset here: in enhanced mode the pins must stay enabled
    // while the reset is held, and the mode input alone decides that.
    always_ff @(posedge i_ref_clk) begin
        o_dma_req_oe_n    <= ~pins_en;
        o_floppy_irq_oe_n <= ~pins_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path; the bus is driven in the cycle after the strobe.

    logic [7:0] rd_d;
    logic       rd_oe_d;

    always_comb begin
        rd_d    = 8'h00;
        rd_oe_d = 1'b0;
        if (i_host.rd && addr_hit(i_host, `OFS_STATUS_SECOND)) begin
            if (i_sys_mode == fdc_ctl_pkg::SYS_ENHANCED) begin
                rd_oe_d = 1'b1;
                // Motor bits follow the pins, so swap and external decode
                // are reported as the drives see them.
                rd_d    = {2'b11,
                           drive_output_control_q[`DOC_SEL_LSB],
                           wr_tog_q, rd_tog_q,
                           write_gate_out_s,
                           ~o_drive.motor_n[1],
                           ~o_drive.motor_n[0]};
            end else if (i_sys_mode == fdc_ctl_pkg::SYS_REDUCED) begin
                rd_oe_d = 1'b1;
                rd_d    = {drv2_s, o_drive.sel_n[1], o_drive.sel_n[0],
                           wr_lat_q, rd_lat_q, write_gate_out_lat_q,
                           o_drive.sel_n[3], o_drive.sel_n[2]};
            end
            // Basic mode leaves the bus floating.
        end else if (i_host.rd && addr_hit(i_host, `OFS_DRIVE_OUTPUT)) begin
            rd_oe_d = 1'b1;
            rd_d    = drive_output_control_q;
        end else if (i_host.rd && addr_hit(i_host, `OFS_TAPE_SELECT)) begin
            rd_oe_d = 1'b1;
            // Bits 7:2 are driven low; only the two select bits come from the register.
            rd_d    = {6'h00, tape_drive_select_q};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata      <= 8'h00;
            o_rdata_oe_n <= 1'b1;
        end else begin
            o_rdata      <= rd_d;
            o_rdata_oe_n <= ~rd_oe_d;
        end
    end

endmodule

/* File: rtl/fdc_ctl_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the floppy drive control register bank.
 * Assumes a 200 MHz reference clock and an 8-bit host I/O bus.
 */
`ifndef FDC_CTL_REGS_SVH
`define FDC_CTL_REGS_SVH

`define OFS_STATUS_SECOND       10'h3F1
`define OFS_DRIVE_OUTPUT        10'h3F2
`define OFS_TAPE_SELECT         10'h3F3
`define OFS_DIGITAL_INPUT       10'h3F7

`define DOC_RESET_VAL           8'h00
`define TDS_RESET_VAL           2'h0

`define DOC_SEL_LSB             0
`define DOC_SEL_MSB             1
`define DOC_SOFT_RESET_N        2
`define DOC_DMA_IRQ_EN          3
`define DOC_MOTOR_LSB           4

`define SRB_ENH_MOTOR1          1
`define SRB_ENH_WRITE_GATE_OUT           2
`define SRB_ENH_RD_TOG          3
`define SRB_ENH_WR_TOG          4
`define SRB_ENH_SEL0            5

`define SOFT_RESET_MIN_NS       100
`define REF_CLK_MHZ             200
`define SOFT_RESET_CYCLES \
    ((`SOFT_RESET_MIN_NS * `REF_CLK_MHZ + 999) / 1000)

`endif
